// ==== cbcl_dev.sv ====
`timescale 1ns/100ps
module cbcl_dev
   import cbcl_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   // link
   cbcl_link_if.dev         link,
   // configuration, held static while the bus runs
   input  wire logic        cfg_is_mem_in,
   input  wire logic [23:0] cfg_base_in,
   input  wire logic [2:0]  cfg_chan_in,
   input  wire logic [3:0]  cfg_waits_in,
   input  wire logic [15:0] rd_data_in,
   // completed access report
   output      logic        acc_valid_out,
   output      logic [23:0] acc_addr_out,
   output      logic        acc_write_out,
   output      logic        acc_io_out,
   output      logic [15:0] acc_wdata_out
);
   typedef struct packed {
      cbcl_dst_t   st;
      logic [47:0] cs1;
      logic [47:0] cs2;
      logic [15:0] p1;
      logic [15:0] p2;
      logic        claim;
      logic        drv;
      logic        rd;
      logic        io;
      logic        seen;
      logic        hold;
      logic [3:0]  cnt;
      logic [15:0] dout;
      logic [15:0] wdata;
      logic        tgl;
   } cbcl_dreg_t;

   typedef struct packed {
      logic        t1;
      logic        t2;
      logic        t3;
      logic        valid;
      logic [23:0] addr;
      logic        write;
      logic        io;
      logic [15:0] wdata;
   } cbcl_ureg_t;

   cbcl_dreg_t d_r;
   cbcl_dreg_t d_nxt;
   cbcl_ureg_t u_r;
   cbcl_ureg_t u_nxt;
   logic       rdy_oe_r;

   logic        c_mem;
   logic [23:0] c_base;
   logic [2:0]  c_chan;
   logic [3:0]  c_waits;
   logic        mem_hit;
   logic        io_hit;
   logic        dma_hit;

   // static settings after their two flops
   assign {c_mem, c_base, c_chan, c_waits} = d_r.cs2[47:16];
   // decode of the phase one word, and of the channel on the live phase two lines
   assign mem_hit = c_mem && !d_r.p1[BIT_IOD] &&
                    d_r.p1[15:2] == c_base[23:10];
   assign io_hit  = !c_mem && !d_r.p1[BIT_MIO] && d_r.p1[BIT_IOD] &&
                    {d_r.p1[7:2], d_r.p1[15:8]} == c_base[15:2];
   assign dma_hit = !c_mem && !d_r.p1[BIT_MIO] && !d_r.p1[BIT_IOD] &&
                    link.mad[5:3] == c_chan;

   // link side next state
   always_comb
   begin
      d_nxt     = d_r;
      d_nxt.cs1 = {cfg_is_mem_in, cfg_base_in, cfg_chan_in, cfg_waits_in,
                   rd_data_in};
      d_nxt.cs2 = d_r.cs1;
      unique case (d_r.st)
         D_IDLE:
         begin
            if (!link.ale)
            begin
               d_nxt.p1 = link.mad;
            end
            else if (mem_hit || io_hit || dma_hit)
            begin
               d_nxt.p2    = link.mad;
               d_nxt.st    = D_ACT;
               // acknowledge target stays silent on the claim line
               d_nxt.claim = mem_hit || io_hit;
               d_nxt.io    = io_hit;
               d_nxt.seen  = 1'b0;
               d_nxt.cnt   = c_waits;
               // the DMA device takes the opposite data direction
               d_nxt.rd    = dma_hit ? link.mad[BIT_WR]
                                     : !link.mad[BIT_WR];
               // hold ready until read data is on the lines
               d_nxt.hold  = !dma_hit &&
                             (c_waits != 4'h0 || !link.mad[BIT_WR]);
            end
         end
         D_ACT:
         begin
            if (!link.cmd_n)
            begin
               d_nxt.seen = 1'b1;
               d_nxt.drv  = d_r.rd;
               d_nxt.dout = d_r.cs2[15:0];
               if (!d_r.rd)
               begin
                  d_nxt.wdata = link.mad;
               end
               if (d_r.cnt != 4'h0)
               begin
                  d_nxt.cnt = d_r.cnt - 4'h1;
               end
               else
               begin
                  d_nxt.hold = 1'b0;
               end
            end
            else if (d_r.seen)
            begin
               d_nxt.drv   = 1'b0;
               d_nxt.claim = 1'b0;
               d_nxt.hold  = 1'b0;
               d_nxt.tgl   = ~d_r.tgl;
               d_nxt.st    = D_IDLE;
            end
         end
      endcase
   end

   // link side register, reset by the bus reset line
   always_ff @(posedge link.atclk or posedge link.bus_rst)
   begin
      if (link.bus_rst)
      begin
         d_r    <= '0;
         d_r.st <= D_IDLE;
      end
      else
      begin
         d_r <= d_nxt;
      end
   end

   // ready changes only on falling edges so fast cycles end cleanly
   always_ff @(negedge link.atclk or posedge link.bus_rst)
   begin
      if (link.bus_rst)
      begin
         rdy_oe_r <= 1'b0;
      end
      else
      begin
         rdy_oe_r <= d_r.hold;
      end
   end

   // user side: toggle crossing; captured fields are stable until
   // the next cycle, many bus clocks later
   always_comb
   begin
      u_nxt       = u_r;
      u_nxt.t1    = d_r.tgl;
      u_nxt.t2    = u_r.t1;
      u_nxt.t3    = u_r.t2;
      u_nxt.valid = u_r.t2 ^ u_r.t3;
      if (u_r.t2 ^ u_r.t3)
      begin
         u_nxt.write = !d_r.rd;
         u_nxt.io    = d_r.io;
         u_nxt.wdata = d_r.wdata;
         if (d_r.io)
         begin
            u_nxt.addr = {8'h00, d_r.p1[7:2], d_r.p1[15:8], d_r.p2[7:6]};
         end
         else
         begin
            u_nxt.addr = {d_r.p1[15:2], d_r.p2[15:6]};
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         u_r <= '0;
      end
      else
      begin
         u_r <= u_nxt;
      end
   end

   // outputs from registers; the claim level is tied low
   assign link.mad_d    = d_r.dout;
   assign link.mad_d_oe = d_r.drv;
   assign link.claim_o  = 1'b0;
   assign link.claim_oe = d_r.claim;
   assign link.rdy_oe   = rdy_oe_r;
   assign acc_valid_out = u_r.valid;
   assign acc_addr_out  = u_r.addr;
   assign acc_write_out = u_r.write;
   assign acc_io_out    = u_r.io;
   assign acc_wdata_out = u_r.wdata;
endmodule : cbcl_dev

// ==== cbcl_host.sv ====
`timescale 1ns/100ps
module cbcl_host
   import cbcl_pkg::*;
#(
   parameter int HALF = DIV_HALF
)(
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               sys_rst_in,
   // link
   cbcl_link_if.host               link,
   // request
   input  wire logic               req_valid_in,
   output      logic               req_ready_out,
   input  wire cbcl_kind_t         req_kind_in,
   input  wire logic [23:0]        req_addr_in,
   input  wire logic               req_write_in,
   input  wire logic               req_bhe_n_in,
   input  wire logic               req_fast_in,
   input  wire logic [15:0]        req_wdata_in,
   input  wire logic [2:0]         req_chan_in,
   input  wire logic               req_tc_in,
   // answer
   output      logic               rsp_valid_out,
   output      logic               rsp_claimed_out,
   output      logic [15:0]        rsp_rdata_out,
   // dma requests caught from drive-back cycles
   input  wire logic [CHAN_N-1:0]  drq_set_in,
   output      logic [CHAN_N-1:0]  dma_map_out
);
   typedef struct packed {
      cbcl_hst_t          st;
      logic [7:0]         div;
      logic               atclk;
      logic               rise;
      logic               fall;
      logic               bus_rst;
      logic               ale;
      logic               cmd_n;
      logic [15:0]        mad;
      logic               mad_oe;
      logic [17:0]        s1;
      logic [17:0]        s2;
      cbcl_kind_t         kind;
      logic               dack;
      logic               fast;
      logic               write;
      logic               tc;
      logic [2:0]         chan;
      logic               chk;
      logic               seen;
      logic               claimed;
      logic               ready;
      logic               rsp_valid;
      logic [15:0]        rsp_rdata;
      logic [CHAN_N-1:0]  map;
   } cbcl_hreg_t;

   cbcl_hreg_t q_r;
   cbcl_hreg_t q_nxt;

   logic [15:0]       mad_s;
   logic              claim_s;
   logic              rdy_s;
   logic              is_dack;
   logic              fast_eff;
   logic [15:0]       ph1;
   logic [15:0]       ph2;
   logic              fin;
   logic [CHAN_N-1:0] clr;

   // synchronised copies of the lines the peripherals drive
   assign mad_s   = q_r.s2[17:2];
   assign claim_s = q_r.s2[1];
   assign rdy_s   = q_r.s2[0];

   // acknowledge cycle only when the channel's request came off this bus
   assign is_dack  = (req_kind_in == CBCL_DMA) && q_r.map[req_chan_in];
   assign fast_eff = (req_kind_in == CBCL_MEM) && req_fast_in;

   // address phase words
   always_comb
   begin
      if (req_kind_in == CBCL_IO)
      begin
         ph1 = {req_addr_in[9:2], req_addr_in[15:10], 2'b10};
      end
      else if (is_dack)
      begin
         ph1 = {req_addr_in[23:10], 2'b00};
      end
      else
      begin
         ph1 = {req_addr_in[23:10], 2'b01};
      end
      if (is_dack)
      begin
         ph2 = {req_addr_in[9:0], req_chan_in, req_tc_in,
                req_bhe_n_in, req_write_in};
      end
      else
      begin
         // lines 5..3 repeat phase one for both memory and I/O
         ph2 = {req_addr_in[9:0], req_addr_in[13:11], fast_eff,
                req_bhe_n_in, req_write_in};
      end
   end

   // next state
   always_comb
   begin
      q_nxt           = q_r;
      fin             = 1'b0;
      clr             = '0;
      q_nxt.rise      = 1'b0;
      q_nxt.fall      = 1'b0;
      q_nxt.rsp_valid = 1'b0;
      q_nxt.bus_rst   = 1'b0;
      q_nxt.s1        = {link.mad, link.claim_n, link.iochrdy};
      q_nxt.s2        = q_r.s1;
      // bus clock divider; edges are acted on one cycle later so that
      // the peripheral samples settled lines
      if (q_r.div == 8'(HALF - 1))
      begin
         q_nxt.div   = 8'h00;
         q_nxt.atclk = ~q_r.atclk;
         q_nxt.rise  = ~q_r.atclk;
         q_nxt.fall  = q_r.atclk;
      end
      else
      begin
         q_nxt.div = q_r.div + 8'h01;
      end
      unique case (q_r.st)
         H_IDLE:
         begin
            if (q_r.ready && req_valid_in)
            begin
               q_nxt.kind   = req_kind_in;
               q_nxt.dack   = is_dack;
               q_nxt.fast   = fast_eff;
               q_nxt.write  = req_write_in;
               q_nxt.tc     = req_tc_in;
               q_nxt.chan   = req_chan_in;
               q_nxt.mad    = ph1;
               q_nxt.mad_oe = 1'b1;
               q_nxt.st     = H_PH1;
            end
         end
         H_PH1:
         begin
            // phase two and ALE go out together on a falling edge
            if (q_r.fall)
            begin
               q_nxt.mad = ph2;
               q_nxt.ale = 1'b1;
               q_nxt.chk = 1'b0;
               q_nxt.st  = H_ALE;
            end
         end
         H_ALE:
         begin
            // first rise: peripherals latch; second rise: look for claim
            if (q_r.rise && !q_r.chk)
            begin
               q_nxt.chk = 1'b1;
            end
            else if (q_r.rise)
            begin
               q_nxt.ale     = 1'b0;
               q_nxt.claimed = ~claim_s;
               if (!claim_s || q_r.dack)
               begin
                  // data moves directly between device and memory on acknowledge; host does not drive
                  q_nxt.mad_oe = q_r.write && !q_r.dack;
                  q_nxt.mad    = req_wdata_in;
                  if (q_r.kind == CBCL_IO || q_r.dack)
                  begin
                     q_nxt.st = H_CMDF;
                  end
                  else
                  begin
                     q_nxt.cmd_n = 1'b0;
                     q_nxt.st    = H_DATA;
                  end
               end
               else
               begin
                  fin = 1'b1; // unclaimed: plain ISA cycle
               end
            end
         end
         H_CMDF:
         begin
            if (q_r.fall)
            begin
               q_nxt.cmd_n = 1'b0;
               q_nxt.st    = H_DATA;
            end
         end
         H_DATA:
         begin
            if (q_r.kind == CBCL_IO && !q_r.dack)
            begin
               if (q_r.rise && rdy_s)
               begin
                  q_nxt.seen = 1'b1;
               end
               if (q_r.fall && q_r.seen)
               begin
                  fin = 1'b1;
               end
            end
            else if (q_r.fast && !q_r.dack)
            begin
               if (q_r.rise && rdy_s)
               begin
                  fin = 1'b1;
               end
            end
            else if (q_r.rise)
            begin
               // one extra edge after ready gives the wait state
               if (q_r.seen)
               begin
                  fin = 1'b1;
               end
               else if (rdy_s)
               begin
                  q_nxt.seen = 1'b1;
               end
            end
         end
         H_GAP:
         begin
            // one rise lets the peripheral release the lines
            if (q_r.rise)
            begin
               q_nxt.st = H_IDLE;
            end
         end
      endcase
      // end of cycle: strobe off, lines released, answer out
      if (fin)
      begin
         q_nxt.cmd_n     = 1'b1;
         q_nxt.mad_oe    = 1'b0;
         q_nxt.seen      = 1'b0;
         q_nxt.rsp_valid = 1'b1;
         q_nxt.rsp_rdata = mad_s;
         q_nxt.st        = H_GAP;
         if (q_r.dack && q_r.tc)
         begin
            clr[q_r.chan] = 1'b1;
         end
      end
      // a request arriving with the clear is kept
      q_nxt.map   = (q_r.map & ~clr) | drq_set_in;
      q_nxt.ready = (q_nxt.st == H_IDLE) && q_nxt.fall &&
                    !(q_r.ready && req_valid_in);
   end

   // state register
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         q_r         <= '0;
         q_r.st      <= H_IDLE;
         q_r.bus_rst <= 1'b1;
         q_r.cmd_n   <= 1'b1;
         q_r.s1      <= 18'h3FFFF;
         q_r.s2      <= 18'h3FFFF;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   // outputs straight from the state register
   assign link.atclk      = q_r.atclk;
   assign link.bus_rst    = q_r.bus_rst;
   assign link.ale        = q_r.ale;
   assign link.cmd_n      = q_r.cmd_n;
   assign link.mad_h      = q_r.mad;
   assign link.mad_h_oe   = q_r.mad_oe;
   assign req_ready_out   = q_r.ready;
   assign rsp_valid_out   = q_r.rsp_valid;
   assign rsp_claimed_out = q_r.claimed;
   assign rsp_rdata_out   = q_r.rsp_rdata;
   assign dma_map_out     = q_r.map;
endmodule : cbcl_host

// ==== cbcl_link_if.sv ====
`timescale 1ns/100ps
interface cbcl_link_if;
   import cbcl_pkg::*;
   logic        atclk;
   logic        bus_rst;
   logic        ale;
   logic        cmd_n;
   logic [15:0] mad_h;
   logic        mad_h_oe;
   logic [15:0] mad_d;
   logic        mad_d_oe;
   logic        claim_o;
   logic        claim_oe;
   logic        rdy_oe;
   logic [15:0] mad;
   logic        claim_n;
   logic        iochrdy;
   // wire levels: undriven lines float high through pull-ups
   assign mad     = mad_h_oe ? mad_h : (mad_d_oe ? mad_d : MAD_IDLE);
   assign claim_n = claim_oe ? claim_o : 1'b1;
   assign iochrdy = ~rdy_oe;
   modport host (output atclk, bus_rst, ale, cmd_n, mad_h, mad_h_oe,
                 input  mad, claim_n, iochrdy);
   modport dev  (input  atclk, bus_rst, ale, cmd_n, mad,
                 output mad_d, mad_d_oe, claim_o, claim_oe, rdy_oe);
endinterface : cbcl_link_if

// ==== cbcl_link_monitor.sv ====
`timescale 1ns/100ps
module cbcl_link_monitor
   import cbcl_pkg::*;
(
   // bus clock and reset
   input  wire logic        atclk,
   input  wire logic        bus_rst,
   // host drive
   input  wire logic        ale,
   input  wire logic        cmd_n,
   input  wire logic        mad_h_oe,
   // peripheral drive
   input  wire logic        mad_d_oe,
   input  wire logic        claim_oe,
   input  wire logic        rdy_oe,
   // resolved lines
   input  wire logic [15:0] mad,
   input  wire logic        claim_n,
   input  wire logic        iochrdy
);
   default clocking mon_cb @(posedge atclk); endclocking
   default disable iff (bus_rst);

   logic       ale_q_r;
   logic [1:0] flag_q_r;
   logic [1:0] kind_r;
   logic       fast_r;
   logic       seen_r;

   // cycle kind kept from phase one, so data-phase checks know it
   always_ff @(posedge atclk or posedge bus_rst)
   begin
      if (bus_rst)
      begin
         ale_q_r  <= 1'b0;
         flag_q_r <= 2'b11;
         kind_r   <= 2'b11; // config kind: no check fires after reset
         fast_r   <= 1'b0;
         seen_r   <= 1'b0;
      end
      else
      begin
         ale_q_r  <= ale;
         flag_q_r <= mad[1:0];
         seen_r   <= !cmd_n && iochrdy;
         if (ale && !ale_q_r)
         begin
            kind_r <= flag_q_r;
            fast_r <= mad[BIT_FAST];
         end
      end
   end

   property p_flags_mem;
      $rose(ale) && flag_q_r[0] |-> !flag_q_r[1] && $past(mad_h_oe);
   endproperty
   a_flags_mem: assert property (p_flags_mem)
      else $error("memory phase one flags wrong");
   property p_keep_mem;
      $rose(ale) && flag_q_r == 2'b01 |-> mad[5:3] == $past(mad[5:3]);
   endproperty
   a_keep_mem: assert property (p_keep_mem)
      else $error("memory phase two changed kept lines");
   property p_io_phase2;
      $rose(ale) && flag_q_r == 2'b10
         |-> !mad[BIT_FAST] && mad[15:8] == $past(mad[15:8]);
   endproperty
   a_io_phase2: assert property (p_io_phase2)
      else $error("io phase two lines wrong");
   property p_claim_ale;
      ale && !claim_n |=> !ale;
   endproperty
   a_claim_ale: assert property (p_claim_ale)
      else $error("latch enable held after claim");
   property p_mem_cmd;
      @(negedge atclk) $fell(ale) && kind_r == 2'b01 && !claim_n |-> !cmd_n;
   endproperty
   a_mem_cmd: assert property (p_mem_cmd)
      else $error("memory strobe not on rising edge");
   property p_io_cmd;
      @(negedge atclk) $fell(ale) && kind_r == 2'b10 && !claim_n
         |-> cmd_n ##1 !cmd_n;
   endproperty
   a_io_cmd: assert property (p_io_cmd)
      else $error("io strobe not on falling edge");
   property p_no_fight;
      !cmd_n && mad_d_oe |-> !mad_h_oe;
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive the lines");
   property p_release;
      $rose(cmd_n) |=> !mad_d_oe && !claim_oe && !rdy_oe;
   endproperty
   a_release: assert property (p_release)
      else $error("peripheral still drives after strobe");
   property p_fast_end;
      kind_r == 2'b01 && fast_r && !cmd_n && iochrdy |=> cmd_n;
   endproperty
   a_fast_end: assert property (p_fast_end)
      else $error("fast strobe not ended");
   property p_slow_end;
      (kind_r == 2'b00 || kind_r == 2'b01 && !fast_r) && !cmd_n && iochrdy
         && !seen_r |=> !cmd_n ##1 cmd_n;
   endproperty
   a_slow_end: assert property (p_slow_end)
      else $error("slow strobe end misplaced");
   property p_io_end;
      kind_r == 2'b10 && !cmd_n && iochrdy |=> cmd_n;
   endproperty
   a_io_end: assert property (p_io_end)
      else $error("io strobe end misplaced");
endmodule : cbcl_link_monitor

// ==== cbcl_pkg.sv ====
// How it works
// - memory phase one: high address, flags
// - memory phase two: low address, command bits
// - peripheral captures phase one on rising clock
// - owner claims, captures phase two at ALE
// - claim means low while ALE high
// - host drops ALE and address on claim
// - reads tristated by host, writes driven
// - memory command strobe on rising edge
// - fast flag gives zero wait states
// - fast: ready released on falling edge
// - fast: strobe ends when ready seen
// - slow: strobe ends one edge later
// - I/O phase one: address split, flags
// - I/O phase two: fast flag forced zero
// - I/O command strobe on falling edge
// - I/O device may hold ready low
// - I/O strobe ends next falling edge
// - host records per-channel bus DMA requests
// - DMA device never drives claim line
// - memory device claims during DMA normally
// - ISA DMA uses normal memory cycle
package cbcl_pkg;
   localparam int MAD_W    = 16;
   localparam int ADDR_W   = 24;
   localparam int CHAN_N   = 8;
   // phase one flag lines
   localparam int BIT_MIO  = 0;
   localparam int BIT_IOD  = 1;
   // phase two command lines
   localparam int BIT_WR   = 0;
   localparam int BIT_BHE  = 1;
   localparam int BIT_FAST = 2;
   // clk_in cycles per half period of the bus clock
   localparam int DIV_HALF = 4;
   localparam logic [15:0] MAD_IDLE = 16'hFFFF;
   typedef enum logic [1:0] {CBCL_MEM, CBCL_IO, CBCL_DMA} cbcl_kind_t;
   typedef enum logic [2:0] {
      H_IDLE, H_PH1, H_ALE, H_CMDF, H_DATA, H_GAP
   } cbcl_hst_t;
   typedef enum logic [0:0] {D_IDLE, D_ACT} cbcl_dst_t;
endpackage : cbcl_pkg

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
   import cbcl_pkg::*;
   // clock, reset and tallies
   logic              clk_in;
   logic              sys_rst_in;
   int                fails;
   int                check_count;
   // host user side
   logic              req_valid, req_ready, req_write, req_bhe_n;
   logic              req_fast, req_tc, rsp_valid, rsp_claimed;
   cbcl_kind_t        req_kind;
   logic [23:0]       req_addr;
   logic [15:0]       req_wdata, rsp_rdata;
   logic [2:0]        req_chan;
   logic [CHAN_N-1:0] drq_set, dma_map;
   // peripheral user side
   logic              cfg_is_mem, acc_valid, acc_write, acc_io;
   logic [23:0]       cfg_base, acc_addr;
   logic [2:0]        cfg_chan;
   logic [3:0]        cfg_waits;
   logic [15:0]       rd_data, acc_wdata;
   logic [41:0]       acc_q[$];

   cbcl_link_if link ();
   cbcl_host cbcl_host_inst (.clk_in (clk_in), .sys_rst_in (sys_rst_in),
      .link (link), .req_valid_in (req_valid), .req_ready_out (req_ready),
      .req_kind_in (req_kind), .req_addr_in (req_addr),
      .req_write_in (req_write), .req_bhe_n_in (req_bhe_n),
      .req_fast_in (req_fast), .req_wdata_in (req_wdata),
      .req_chan_in (req_chan), .req_tc_in (req_tc),
      .rsp_valid_out (rsp_valid), .rsp_claimed_out (rsp_claimed),
      .rsp_rdata_out (rsp_rdata), .drq_set_in (drq_set),
      .dma_map_out (dma_map));
   cbcl_dev cbcl_dev_inst (.clk_in (clk_in), .sys_rst_in (sys_rst_in),
      .link (link), .cfg_is_mem_in (cfg_is_mem), .cfg_base_in (cfg_base),
      .cfg_chan_in (cfg_chan), .cfg_waits_in (cfg_waits),
      .rd_data_in (rd_data), .acc_valid_out (acc_valid),
      .acc_addr_out (acc_addr), .acc_write_out (acc_write),
      .acc_io_out (acc_io), .acc_wdata_out (acc_wdata));
   cbcl_link_monitor cbcl_link_monitor_inst (.atclk (link.atclk),
      .bus_rst (link.bus_rst), .ale (link.ale), .cmd_n (link.cmd_n),
      .mad_h_oe (link.mad_h_oe), .mad_d_oe (link.mad_d_oe),
      .claim_oe (link.claim_oe), .rdy_oe (link.rdy_oe), .mad (link.mad),
      .claim_n (link.claim_n), .iochrdy (link.iochrdy));

   // 250 MHz system clock
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // reports queued so back-to-back cycles lose none
   always @(negedge clk_in)
      if (acc_valid === 1'b1)
         acc_q.push_back({acc_io, acc_write, acc_wdata, acc_addr});

   task automatic chk(input logic [41:0] got, input logic [41:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // next report, masked where the field has no meaning
   task automatic chk_acc(input logic [41:0] exp, input logic [41:0] msk);
      int          n;
      logic [41:0] got;
      n = 0;
      got = 'x;
      while (acc_q.size() == 0 && n < 80)
      begin
         @(negedge clk_in);
         n++;
      end
      if (acc_q.size() > 0)
         got = acc_q.pop_front();
      chk(got & msk, exp);
   endtask : chk_acc

   // config is static: change it idle and let it settle five bus clocks
   task automatic set_dev(input logic m, input logic [23:0] b,
                          input logic [3:0] w, input logic [15:0] rd,
                          input logic [2:0] ch);
      @(negedge clk_in);
      cfg_is_mem <= m;
      cfg_base   <= b;
      cfg_waits  <= w;
      rd_data    <= rd;
      cfg_chan   <= ch;
      repeat (40) @(negedge clk_in);
      acc_q.delete();
   endtask : set_dev

   // one host request, fields held until the answer
   task automatic bus_op(input cbcl_kind_t k, input logic [23:0] a,
                         input logic w, input logic f,
                         input logic [15:0] wd, input logic [2:0] ch,
                         input logic tc);
      int n;
      @(negedge clk_in);
      req_kind  <= k;
      req_addr  <= a;
      req_write <= w;
      req_fast  <= f;
      req_wdata <= wd;
      req_chan  <= ch;
      req_tc    <= tc;
      req_valid <= 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100)
      begin
         @(negedge clk_in);
         n++;
      end
      @(negedge clk_in);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < 3000)
      begin
         @(negedge clk_in);
         n++;
      end
      chk(42'(rsp_valid), 42'h1);
   endtask : bus_op

   task automatic t_mem_fast();
      set_dev(1'b1, 24'hA40000, 4'h0, 16'h5AC3, 3'h0);
      bus_op(CBCL_MEM, 24'hA403FE, 1'b1, 1'b1, 16'hC35A, 3'h0, 1'b0);
      chk(42'(rsp_claimed), 42'h1);
      bus_op(CBCL_MEM, 24'hA40155, 1'b0, 1'b1, 16'h0000, 3'h0, 1'b0);
      chk(42'(rsp_rdata), 42'h5AC3);
      chk_acc({2'b01, 16'hC35A, 24'hA403FE}, 42'h3FFFFFFFFFF);
      chk_acc({2'b00, 16'h0000, 24'hA40155}, 42'h30000FFFFFF);
   endtask : t_mem_fast

   task automatic t_mem_slow();
      set_dev(1'b1, 24'h0FFC00, 4'h3, 16'h3C96, 3'h0);
      bus_op(CBCL_MEM, 24'h0FFFFF, 1'b0, 1'b0, 16'h0000, 3'h0, 1'b0);
      chk(42'(rsp_rdata), 42'h3C96);
      bus_op(CBCL_MEM, 24'h0FFC00, 1'b1, 1'b0, 16'h8001, 3'h0, 1'b0);
      chk_acc({2'b00, 16'h0000, 24'h0FFFFF}, 42'h30000FFFFFF);
      chk_acc({2'b01, 16'h8001, 24'h0FFC00}, 42'h3FFFFFFFFFF);
   endtask : t_mem_slow

   task automatic t_io();
      set_dev(1'b0, 24'h000300, 4'h1, 16'hA55A, 3'h0);
      bus_op(CBCL_IO, 24'h000302, 1'b1, 1'b1, 16'h0FF0, 3'h0, 1'b0);
      chk(42'(rsp_claimed), 42'h1);
      bus_op(CBCL_IO, 24'h000301, 1'b0, 1'b1, 16'h0000, 3'h0, 1'b0);
      chk(42'(rsp_rdata), 42'hA55A);
      chk_acc({2'b11, 16'h0FF0, 24'h000302}, 42'h3FFFF00FFFF);
      chk_acc({2'b10, 16'h0000, 24'h000301}, 42'h3000000FFFF);
   endtask : t_io

   // address outside the window: nobody claims
   task automatic t_miss();
      set_dev(1'b1, 24'hA40000, 4'h0, 16'h1111, 3'h0);
      bus_op(CBCL_MEM, 24'hA80000, 1'b0, 1'b1, 16'h0000, 3'h0, 1'b0);
      chk(42'(rsp_claimed), 42'h0);
      repeat (60) @(negedge clk_in);
      chk(42'(acc_q.size()), 42'h0);
   endtask : t_miss

   task automatic t_dma();
      @(negedge clk_in);
      drq_set <= 8'h20;
      @(negedge clk_in);
      drq_set <= 8'h00;
      @(negedge clk_in);
      chk(42'(dma_map), 42'h20);
      set_dev(1'b0, 24'h000300, 4'h0, 16'h2468, 3'h5);
      bus_op(CBCL_DMA, 24'hA40010, 1'b1, 1'b0, 16'h0000, 3'h5, 1'b0);
      chk(42'(rsp_claimed), 42'h0);
      set_dev(1'b1, 24'hA40000, 4'h2, 16'h2468, 3'h0);
      bus_op(CBCL_DMA, 24'hA40012, 1'b0, 1'b0, 16'h0000, 3'h5, 1'b1);
      chk(42'(rsp_claimed), 42'h1);
      chk_acc({2'b00, 16'h0000, 24'hA40012}, 42'h30000FFFFFF);
      chk(42'(dma_map), 42'h00);
      bus_op(CBCL_DMA, 24'hA40014, 1'b1, 1'b0, 16'h7E81, 3'h5, 1'b0);
      chk(42'(rsp_claimed), 42'h1);
      chk_acc({2'b01, 16'h7E81, 24'hA40014}, 42'h3FFFFFFFFFF);
   endtask : t_dma

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   // the whole run needs under two thousand cycles
   initial
   begin
      repeat (30000) @(posedge clk_in);
      fails++;
      test_done();
   end

   initial
   begin
      fails = 0;
      check_count = 0;
      {req_valid, req_write, req_bhe_n, req_fast, req_tc} = 5'h00;
      req_kind = CBCL_MEM;
      {req_addr, req_wdata, req_chan, drq_set} = 51'h0;
      {cfg_is_mem, cfg_base, cfg_chan, cfg_waits, rd_data} = 48'h0;
      sys_rst_in = 1'b1;
      repeat (4) @(negedge clk_in);
      sys_rst_in = 1'b0;
      t_mem_fast();
      t_mem_slow();
      t_io();
      t_miss();
      t_dma();
      test_done();
   end
endmodule : tb
